// ### bwe_pkg.sv
// Package for the byte-wide programmable memory host controller
package bwe_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int MEM_WORDS = 524288;
  localparam int CLK_PERIOD_NS = 4;
  localparam int PROG_PULSE_NS = 100000;
  localparam int PROG_PULSE_CYC = (PROG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_NS = 40;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_NS = 200;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_RETRY = 10;
  localparam int ID_MODE_BIT = 9;
  localparam int ID_SEL_BIT = 0;
  localparam logic [2:0] CMD_READ = 3'h0;
  localparam logic [2:0] CMD_PROG = 3'h1;
  localparam logic [2:0] CMD_FINAL = 3'h2;
  localparam logic [2:0] CMD_SIG = 3'h3;
  localparam logic [2:0] CMD_FIRST = 3'h4;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_SETUP = 7'h02,
    ST_PULSE = 7'h04,
    ST_RECOVER = 7'h08,
    ST_SAMPLE = 7'h10,
    ST_CHECK = 7'h20,
    ST_DONE = 7'h40
  } bwe_state_e;
endpackage : bwe_pkg

// ### bwe_host.sv
// Host controller that reads, programs, verifies and identifies the memory through its pins
`timescale 1ns/1ns
// Summary of operation
// - Output gate high floats device data, as does chip select high at nominal supply; host drives data only with the gate high.
// - Programming: supply elevated, output gate high, chip select pulsed low.
// - Address and all eight data bits presented before each program pulse.
// - Pulse starts after setup and lasts the programming pulse width.
// - First pass gives every location exactly one pulse, no verify.
// - Verify: chip select high, output gate low, elevated supplies.
// - On mismatch with no wanted one read as zero, pulse again; at most ten pulses per location.
// - Final pass reads back every byte at nominal supplies.
// - Signature: id line high voltage, strobes low, select picks code.
// - Both strobes high with elevated supply inhibits programming.
// - Signature read holds all other address lines low.
module bwe_host
  import bwe_pkg::*;
#(
  parameter int PULSE_CYC = PROG_PULSE_CYC,
  parameter int RETRIES = MAX_RETRY
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_op_i,
  input wire logic [ADDR_W-1:0] cmd_addr_i,
  input wire logic [DATA_W-1:0] cmd_data_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic fail_o,
  output logic [DATA_W-1:0] rdata_o,
  output logic [3:0] pulses_o,
  output logic [ADDR_W-1:0] byte_address_lines_o,
  output logic chip_select_low_o,
  output logic output_gate_low_o,
  output logic program_supply_high_o,
  output logic core_supply_high_o,
  output logic id_high_voltage_o,
  input wire logic [DATA_W-1:0] data_io_lines_i,
  output logic [DATA_W-1:0] data_io_lines_o,
  output logic data_io_lines_oe_o
);
  initial begin
    if (PULSE_CYC < 1 || RETRIES < 1 || RETRIES > 15) begin
      $error("bwe_host: bad parameter");
    end
  end

  localparam int CW = $clog2(PULSE_CYC + ACCESS_CYC + SETUP_CYC + 2);

  bwe_state_e state_q;
  logic [CW-1:0] cnt_q;
  logic [2:0] op_q;
  logic [DATA_W-1:0] want_q;
  logic [DATA_W-1:0] sync1_q;
  logic [DATA_W-1:0] sync2_q;
  logic [3:0] pulses_q;

  // Two-stage synchroniser on the data pins
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= data_io_lines_i;
      sync2_q <= sync1_q;
    end
  end

  // Sequencer
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      op_q <= CMD_READ;
      want_q <= ERASED_BYTE;
      pulses_q <= 4'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cmd_valid_i) begin
            op_q <= cmd_op_i;
            want_q <= cmd_data_i;
            pulses_q <= 4'h0;
            cnt_q <= CW'(SETUP_CYC);
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // Address and data settle before any strobe moves
          if (cnt_q > CW'(1)) begin
            cnt_q <= cnt_q - CW'(1);
          end else if (op_q == CMD_PROG || op_q == CMD_FIRST) begin
            cnt_q <= CW'(PULSE_CYC);
            state_q <= ST_PULSE;
          end else begin
            cnt_q <= CW'(ACCESS_CYC);
            state_q <= ST_SAMPLE;
          end
        end
        ST_PULSE: begin
          if (cnt_q > CW'(1)) begin
            cnt_q <= cnt_q - CW'(1);
          end else begin
            pulses_q <= pulses_q + 4'h1;
            cnt_q <= CW'(SETUP_CYC);
            state_q <= ST_RECOVER;
          end
        end
        ST_RECOVER: begin
          if (cnt_q > CW'(1)) begin
            cnt_q <= cnt_q - CW'(1);
          end else if (op_q == CMD_FIRST) begin
            state_q <= ST_DONE;
          end else begin
            cnt_q <= CW'(ACCESS_CYC);
            state_q <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (cnt_q > CW'(1)) begin
            cnt_q <= cnt_q - CW'(1);
          end else begin
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          // a zero read where one is wanted cannot be repaired
          if (op_q == CMD_PROG && sync2_q != want_q && (~sync2_q & want_q) == 8'h00
              && pulses_q < 4'(RETRIES)) begin
            cnt_q <= CW'(SETUP_CYC);
            state_q <= ST_SETUP;
          end else begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Result outputs
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      done_o <= 1'b0;
      fail_o <= 1'b0;
      rdata_o <= 8'h00;
      pulses_o <= 4'h0;
      cmd_ready_o <= 1'b0;
    end else begin
      cmd_ready_o <= (state_q == ST_IDLE) && !cmd_valid_i;
      done_o <= (state_q == ST_CHECK) && !(op_q == CMD_PROG && sync2_q != want_q
                && (~sync2_q & want_q) == 8'h00 && pulses_q < 4'(RETRIES))
                || (state_q == ST_RECOVER && op_q == CMD_FIRST && cnt_q <= CW'(1));
      if (state_q == ST_CHECK) begin
        rdata_o <= sync2_q;
        pulses_o <= pulses_q;
        fail_o <= ((op_q == CMD_PROG || op_q == CMD_FINAL) && sync2_q != want_q);
      end else if (state_q == ST_RECOVER && op_q == CMD_FIRST) begin
        pulses_o <= pulses_q;
        fail_o <= 1'b0;
      end
    end
  end

  // Pin drive
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      byte_address_lines_o <= '0;
      chip_select_low_o <= 1'b1;
      output_gate_low_o <= 1'b1;
      program_supply_high_o <= 1'b0;
      core_supply_high_o <= 1'b0;
      id_high_voltage_o <= 1'b0;
      data_io_lines_o <= 8'h00;
      data_io_lines_oe_o <= 1'b0;
    end else begin
      if (state_q == ST_IDLE && cmd_valid_i) begin
        if (cmd_op_i == CMD_SIG) begin
          byte_address_lines_o <= '0;
          byte_address_lines_o[ID_SEL_BIT] <= cmd_addr_i[ID_SEL_BIT];
        end else begin
          byte_address_lines_o <= cmd_addr_i;
        end
        data_io_lines_o <= cmd_data_i;
      end
      if (state_q == ST_IDLE || state_q == ST_DONE) begin
        chip_select_low_o <= 1'b1;
        output_gate_low_o <= 1'b1;
        data_io_lines_oe_o <= 1'b0;
        program_supply_high_o <= 1'b0;
        core_supply_high_o <= 1'b0;
        id_high_voltage_o <= 1'b0;
        if (cmd_valid_i && state_q == ST_IDLE) begin
          program_supply_high_o <= cmd_op_i == CMD_PROG || cmd_op_i == CMD_FIRST;
          core_supply_high_o <= cmd_op_i == CMD_PROG || cmd_op_i == CMD_FIRST;
          id_high_voltage_o <= cmd_op_i == CMD_SIG;
        end
      end else if (state_q == ST_SETUP || state_q == ST_RECOVER) begin
        // both strobes high, nothing programmed, device floats
        chip_select_low_o <= 1'b1;
        output_gate_low_o <= 1'b1;
        data_io_lines_oe_o <= (op_q == CMD_PROG || op_q == CMD_FIRST)
                              && !(state_q == ST_RECOVER && cnt_q <= CW'(1));
        if (state_q == ST_SETUP && cnt_q <= CW'(1)) begin
          if (op_q == CMD_PROG || op_q == CMD_FIRST) begin
            chip_select_low_o <= 1'b0;
          end else if (op_q == CMD_READ || op_q == CMD_FINAL || op_q == CMD_SIG) begin
            chip_select_low_o <= 1'b0;
            output_gate_low_o <= 1'b0;
          end else begin
            output_gate_low_o <= 1'b0;
          end
        end else if (state_q == ST_RECOVER && cnt_q <= CW'(1) && op_q == CMD_PROG) begin
          output_gate_low_o <= 1'b0;
        end
      end else if (state_q == ST_PULSE) begin
        chip_select_low_o <= cnt_q <= CW'(1);
        output_gate_low_o <= 1'b1;
      end else if (state_q == ST_CHECK) begin
        chip_select_low_o <= 1'b1;
        output_gate_low_o <= 1'b1;
        data_io_lines_oe_o <= 1'b0;
      end
    end
  end
endmodule : bwe_host

// ### bwe_host_chk.sv
// Pin assertions for the host controller
`timescale 1ns/1ns
module bwe_host_chk
  import bwe_pkg::*;
#(parameter int PULSE_CYC = 5, parameter int RETRIES = 10) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [3:0] pulses_o,
  input wire logic [ADDR_W-1:0] byte_address_lines_o,
  input wire logic chip_select_low_o,
  input wire logic output_gate_low_o,
  input wire logic program_supply_high_o,
  input wire logic core_supply_high_o,
  input wire logic id_high_voltage_o,
  input wire logic [DATA_W-1:0] data_io_lines_o,
  input wire logic data_io_lines_oe_o
);
  int low_q;
  // Counts cycles with chip select low, for the pulse width check
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      low_q <= 0;
    end else if (chip_select_low_o) begin
      low_q <= 0;
    end else begin
      low_q <= low_q + 1;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  a_no_fight: assert property (
    !output_gate_low_o |-> !data_io_lines_oe_o) else $error("fight");
  a_prog_mode: assert property (
    !chip_select_low_o && program_supply_high_o |-> output_gate_low_o && data_io_lines_oe_o)
    else $error("prog");
  a_data_setup: assert property (
    $fell(chip_select_low_o) && program_supply_high_o
    |-> $stable(byte_address_lines_o) && $stable(data_io_lines_o)) else $error("setup");
  a_pulse_width: assert property (
    $rose(chip_select_low_o) && $past(program_supply_high_o) |-> low_q == PULSE_CYC)
    else $error("width");
  a_retry_cap: assert property (pulses_o <= RETRIES) else $error("retry");
  a_verify_cfg: assert property (
    program_supply_high_o && !output_gate_low_o |-> chip_select_low_o && core_supply_high_o)
    else $error("verify");
  a_sig_addr: assert property (
    id_high_voltage_o |-> (byte_address_lines_o & ~19'h00201) == 19'h00000) else $error("sig");
  a_sig_strobes: assert property (
    id_high_voltage_o && !output_gate_low_o |-> !chip_select_low_o && !program_supply_high_o)
    else $error("sig mode");
  cover property ($rose(chip_select_low_o) && program_supply_high_o);
  cover property (id_high_voltage_o && !chip_select_low_o);
  cover property (pulses_o == 4'hA);
endmodule // bwe_host_chk
bind bwe_host bwe_host_chk #(.PULSE_CYC(PULSE_CYC), .RETRIES(RETRIES)) bwe_host_chk_i (
  .clock_i(clock_i), .reset_i(reset_i), .pulses_o(pulses_o),
  .byte_address_lines_o(byte_address_lines_o), .chip_select_low_o(chip_select_low_o),
  .output_gate_low_o(output_gate_low_o), .program_supply_high_o(program_supply_high_o),
  .core_supply_high_o(core_supply_high_o), .id_high_voltage_o(id_high_voltage_o),
  .data_io_lines_o(data_io_lines_o), .data_io_lines_oe_o(data_io_lines_oe_o)
);

// ### bwe_mem.sv
// Behavioural model of the programmable memory
`timescale 1ns/1ns
module bwe_mem
  import bwe_pkg::*;
#(parameter logic [7:0] MAKER_ID = 8'h00, parameter logic [7:0] PART_ID = 8'h00) (
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic cs_low_i,
  input wire logic gate_low_i,
  input wire logic vpp_i,
  input wire logic vh_i,
  input wire logic [DATA_W-1:0] din_i,
  input wire logic [3:0] need_i,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_o
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  int hits [logic [ADDR_W-1:0]];
  always @* begin
    dq_oe_o = !gate_low_i && (!cs_low_i || vpp_i);
    if (vh_i)
      dq_o = addr_i[ID_SEL_BIT] ? PART_ID : MAKER_ID;
    else
      dq_o = mem.exists(addr_i) ? mem[addr_i] : ERASED_BYTE;
  end
  always @(negedge cs_low_i) begin
    if (vpp_i && gate_low_i) begin
      hits[addr_i] = hits.exists(addr_i) ? hits[addr_i] + 1 : 1;
      if (!mem.exists(addr_i))
        mem[addr_i] = ERASED_BYTE;
      if (hits[addr_i] >= need_i)
        mem[addr_i] = mem[addr_i] & din_i;
    end
  end
endmodule // bwe_mem

// ### tb.sv
// Self-checking bench for the host controller
`timescale 1ns/1ns
module tb;
  import bwe_pkg::*;
  typedef struct {logic [2:0] op; logic [ADDR_W-1:0] a; logic [7:0] d; logic [7:0] x;} bwe_row_s;
  localparam logic [7:0] MK = 8'h3C; // Arbitrary identifier value
  localparam logic [7:0] PT = 8'hC3; // Arbitrary identifier value
  logic clock_i, reset_i, valid, done, fail, ready, cs_low, gate_low, vpp, vh, hoe, doe;
  logic [2:0] op;
  logic [ADDR_W-1:0] addr, pins;
  logic [7:0] wd, rd, hd, dd, dq, last_q, got;
  logic [3:0] pulses, need;
  int bad_count, cmp_count, i, w;
  bwe_row_s rows [10] = '{
    '{3'h0, 19'h00010, 8'h00, 8'hFF}, '{3'h4, 19'h00010, 8'hA5, 8'h01},
    '{3'h0, 19'h00010, 8'h00, 8'hA5}, '{3'h1, 19'h00010, 8'h05, 8'h00},
    '{3'h2, 19'h00010, 8'h05, 8'h00}, '{3'h2, 19'h00010, 8'h07, 8'h01},
    '{3'h1, 19'h00010, 8'hFF, 8'h01}, '{3'h3, 19'h00000, 8'h00, MK},
    '{3'h3, 19'h00001, 8'h00, PT}, '{3'h4, 19'h7FFFF, 8'h00, 8'h01}};
  assign dq = doe ? dd : hoe ? hd : ~last_q;
  bwe_host #(.PULSE_CYC(5)) bwe_host_i (
    .clock_i(clock_i), .reset_i(reset_i), .cmd_valid_i(valid), .cmd_op_i(op),
    .cmd_addr_i(addr), .cmd_data_i(wd), .cmd_ready_o(ready), .done_o(done), .fail_o(fail),
    .rdata_o(rd), .pulses_o(pulses), .byte_address_lines_o(pins), .chip_select_low_o(cs_low),
    .output_gate_low_o(gate_low), .program_supply_high_o(vpp), .core_supply_high_o(),
    .id_high_voltage_o(vh), .data_io_lines_i(dq), .data_io_lines_o(hd),
    .data_io_lines_oe_o(hoe));
  bwe_mem #(.MAKER_ID(MK), .PART_ID(PT)) bwe_mem_i (
    .addr_i(pins), .cs_low_i(cs_low), .gate_low_i(gate_low), .vpp_i(vpp), .vh_i(vh),
    .din_i(dq), .need_i(need), .dq_o(dd), .dq_oe_o(doe));
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(string n, logic [7:0] e, logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic run(logic [2:0] o, logic [ADDR_W-1:0] a, logic [7:0] d);
    w = 0;
    while (ready !== 1'b1 && w < 9999) begin
      @(posedge clock_i);
      #1;
      w++;
    end
    @(posedge clock_i);
    valid <= 1'b1;
    op <= o;
    addr <= a;
    wd <= d;
    @(posedge clock_i);
    valid <= 1'b0;
    do begin
      @(posedge clock_i);
      #1;
      w++;
    end while (done !== 1'b1 && w < 9999);
    if (w >= 9999) begin
      bad_count++;
      summarize();
    end
  endtask
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  always @(posedge clock_i) last_q <= dq;
  initial begin
    {reset_i, valid, op, addr, wd, need} = {1'b1, 31'h0, 4'h1};
    repeat (8) @(posedge clock_i);
    #1;
    check("idle pins", 8'h03, {3'h0, hoe, vpp, vh, cs_low, gate_low});
    @(posedge clock_i);
    reset_i <= 1'b0;
    $display("reset test done");
    for (i = 0; i < 10; i++) begin
      run(rows[i].op, rows[i].a, rows[i].d);
      got = rows[i].op == 3'h4 ? {4'h0, pulses} : rows[i].op inside {3'h1, 3'h2} ? {7'h0, fail} : rd;
      check("row", rows[i].x, got);
      $display("row %0d done", i);
    end
    need = 4'h3;
    run(CMD_PROG, 19'h00020, 8'h3C);
    check("retry", 8'h03, {3'h0, fail, pulses});
    need = 4'hC;
    run(CMD_PROG, 19'h00030, 8'h0F);
    check("limit", 8'h1A, {3'h0, fail, pulses});
    $display("retry tests done");
    summarize();
  end
endmodule // tb
